// [verilog/rq_descriptor_write_framer.sv]
// requester request framer: descriptor capture, header build, apb control
`timescale 1ns/1ps
module rq_descriptor_write_framer import framer_pkg::*; #(
  parameter int DATA_W = 128,
  parameter int SIDEBAND_W = 8,
  parameter int ADDR_W = 12
) (
  input wire logic mclk,
  input wire logic arst_n,
  // apb register port
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // request stream from user logic
  input wire logic [DATA_W-1:0] req_stream_data,
  input wire logic req_stream_valid,
  output logic req_stream_ready,
  input wire logic req_stream_last,
  input wire logic [DATA_W/32-1:0] req_stream_dword_keep,
  input wire logic [SIDEBAND_W-1:0] req_stream_sideband,
  // bus and device captured from configuration requests
  input wire logic [7:0] cfg_bus_num,
  input wire logic [4:0] cfg_dev_num,
  // framed request toward the link
  output logic tlp_valid,
  input wire logic tlp_ready,
  output logic [DATA_W-1:0] tlp_data,
  output logic [DATA_W/32-1:0] tlp_keep,
  output logic tlp_last,
  output logic tlp_hdr_valid,
  output logic [127:0] tlp_hdr,
  output logic tlp_digest,
  output logic tlp_nullify
);
  localparam int DWORDS = DATA_W / 32;

  // control and status state
  logic [3:0] ctrl_r;
  logic [31:0] pkt_cnt_r;
  logic [31:0] null_cnt_r;
  logic [31:0] prdata_r;
  logic pslverr_r;

  // packet tracking
  logic in_pkt_r;
  logic err_r;
  logic [3:0] head_mask_r;
  logic [3:0] tail_mask_r;

  // output stage
  logic out_valid_r;
  logic [DATA_W-1:0] out_data_r;
  logic [DWORDS-1:0] out_keep_r;
  logic out_last_r;
  logic out_sop_r;
  logic out_null_r;
  logic [127:0] hdr_r;
  logic digest_r;

  // collector and builder results
  logic [DESC_W-1:0] desc_now;
  logic [DWORDS-1:0] desc_lanes;
  logic desc_done;
  logic [127:0] hdr_now;
  logic digest_now;

  // ready whenever the output stage is empty or being drained
  wire beat_fire = req_stream_valid && req_stream_ready;
  wire first_beat = beat_fire && !in_pkt_r;
  wire end_beat = beat_fire && req_stream_last;
  // a gap in valid while a packet is open is an error
  wire valid_gap = in_pkt_r && !req_stream_valid;
  wire err_now = err_r || valid_gap;

  // byte masks sampled from the first beat of each packet
  wire [3:0] head_mask_now = first_beat
    ? req_stream_sideband[SB_HEAD_LSB +: 4] : head_mask_r;
  wire [3:0] tail_mask_now = first_beat
    ? req_stream_sideband[SB_TAIL_LSB +: 4] : tail_mask_r;

  // apb decode
  wire apb_setup = psel && !penable;
  wire apb_write = psel && penable && pwrite;
  wire hit_ctrl = paddr == ADDR_W'(CTRL_OFS);
  wire hit_status = paddr == ADDR_W'(STATUS_OFS);
  wire hit_pkt = paddr == ADDR_W'(PKT_CNT_OFS);
  wire hit_null = paddr == ADDR_W'(NULL_CNT_OFS);
  wire hit_any = hit_ctrl || hit_status || hit_pkt || hit_null;
  wire clr_null = apb_write && hit_null;
  wire pkt_done = out_valid_r && tlp_ready && out_last_r;
  wire null_done = pkt_done && out_null_r;

  // read data for the addressed register
  wire [31:0] status_word = {29'h0, out_valid_r, err_r, in_pkt_r};
  wire [31:0] rd_mux = hit_ctrl ? {28'h0, ctrl_r}
    : hit_status ? status_word
    : hit_pkt ? pkt_cnt_r
    : hit_null ? null_cnt_r
    : 32'h0;

  desc_collector #(
    .DWORDS(DWORDS)
  ) u_collect (
    .mclk(mclk),
    .arst_n(arst_n),
    .beat_fire(beat_fire),
    .beat_last(req_stream_last),
    .beat_data(req_stream_data),
    .desc_now(desc_now),
    .desc_lanes(desc_lanes),
    .desc_done(desc_done)
  );

  tlp_header_builder u_build (
    .desc(desc_now),
    .head_mask(head_mask_now),
    .tail_mask(tail_mask_now),
    .ctrl(ctrl_r),
    .cfg_bus_num(cfg_bus_num),
    .cfg_dev_num(cfg_dev_num),
    .hdr(hdr_now),
    .digest(digest_now)
  );

  // stall the user side while the output beat is not taken
  assign req_stream_ready = !out_valid_r || tlp_ready;

  // apb answers without wait states
  assign pready = 1'b1;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;

  // read data and error captured in the setup cycle
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      prdata_r <= 32'h0;
      pslverr_r <= 1'b0;
    end else if (apb_setup) begin
      prdata_r <= pwrite ? 32'h0 : rd_mux;
      pslverr_r <= !hit_any;
    end
  end

  // control register, attribute and ecrc enables
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= CTRL_RESET;
    end else if (apb_write && hit_ctrl) begin
      ctrl_r <= pwdata[3:0];
    end
  end

  // packet counter, counts every framed request leaving
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pkt_cnt_r <= 32'h0;
    end else if (apb_write && hit_pkt) begin
      pkt_cnt_r <= pkt_done ? 32'h1 : 32'h0;
    end else if (pkt_done) begin
      pkt_cnt_r <= pkt_cnt_r + 32'h1;
    end
  end

  // nullified counter, a new event beats a clearing write
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      null_cnt_r <= 32'h0;
    end else if (clr_null) begin
      null_cnt_r <= null_done ? 32'h1 : 32'h0;
    end else if (null_done) begin
      null_cnt_r <= null_cnt_r + 32'h1;
    end
  end

  // open packet flag, closed by the final beat
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      in_pkt_r <= 1'b0;
    end else if (beat_fire) begin
      in_pkt_r <= !req_stream_last;
    end
  end

  // sticky error until the packet ends
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      err_r <= 1'b0;
    end else if (end_beat) begin
      err_r <= 1'b0;
    end else if (valid_gap) begin
      err_r <= 1'b1;
    end
  end

  // masks held for the rest of the packet
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      head_mask_r <= 4'h0;
      tail_mask_r <= 4'h0;
    end else if (first_beat) begin
      head_mask_r <= head_mask_now;
      tail_mask_r <= tail_mask_now;
    end
  end

  // header held from the beat that completes the descriptor
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      hdr_r <= 128'h0;
      digest_r <= 1'b0;
    end else if (desc_done) begin
      hdr_r <= hdr_now;
      digest_r <= digest_now;
    end
  end

  // output valid follows accepted beats
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      out_valid_r <= 1'b0;
    end else if (req_stream_ready) begin
      out_valid_r <= beat_fire;
    end
  end

  // payload beat: descriptor lanes dropped, payload kept in place
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      out_data_r <= '0;
      out_keep_r <= '0;
      out_last_r <= 1'b0;
      out_sop_r <= 1'b0;
      out_null_r <= 1'b0;
    end else if (beat_fire) begin
      out_data_r <= req_stream_data;
      out_keep_r <= req_stream_dword_keep & ~desc_lanes;
      out_last_r <= req_stream_last;
      out_sop_r <= desc_done;
      out_null_r <= req_stream_last && err_now;
    end
  end

  // outward stream
  assign tlp_valid = out_valid_r;
  assign tlp_data = out_data_r;
  assign tlp_keep = out_keep_r;
  assign tlp_last = out_last_r;
  assign tlp_hdr_valid = out_valid_r && out_sop_r;
  assign tlp_hdr = hdr_r;
  assign tlp_digest = digest_r;
  assign tlp_nullify = out_valid_r && out_null_r;
endmodule

// [verilog/framer_pkg.sv]
// shared constants for the request descriptor framer
package framer_pkg;
  localparam int DESC_W = 128;
  localparam int DESC_DWORDS = 4;
  // descriptor field positions
  localparam int FORCE_ECRC_BIT = 127;
  localparam int IDO_BIT = 126;
  localparam int RO_BIT = 125;
  localparam int NS_BIT = 124;
  localparam int TC_MSB = 123;
  localparam int TC_LSB = 121;
  localparam int RID_EN_BIT = 120;
  localparam int ROUTE_MSB = 114;
  localparam int ROUTE_LSB = 112;
  localparam int MSG_CODE_MSB = 111;
  localparam int MSG_CODE_LSB = 104;
  localparam int REQ_BUS_MSB = 95;
  localparam int REQ_BUS_LSB = 88;
  localparam int REQ_DEV_MSB = 87;
  localparam int REQ_DEV_LSB = 83;
  localparam int REQ_FN_MSB = 82;
  localparam int REQ_FN_LSB = 80;
  localparam int REQ_TYPE_MSB = 78;
  localparam int REQ_TYPE_LSB = 75;
  localparam int LEN_MSB = 74;
  localparam int LEN_LSB = 64;
  localparam int OBFF_MSB = 35;
  localparam int OBFF_LSB = 32;
  // request kinds carried in the descriptor type field, message codes in its code field
  localparam logic [3:0] REQ_MEM_WR = 4'h1;
  localparam logic [3:0] REQ_MSG = 4'hc;
  localparam logic [3:0] REQ_MSG_VD = 4'hd;
  localparam logic [3:0] REQ_MSG_ATS = 4'he;
  localparam logic [7:0] MSG_CODE_LTR = 8'h10;
  localparam logic [7:0] MSG_CODE_OBFF = 8'h12;
  // header encodings
  localparam logic [2:0] FMT_4DW_DATA = 3'h3;
  localparam logic [2:0] FMT_4DW_NODATA = 3'h1;
  localparam logic [1:0] TYPE_MSG_HI = 2'h2;
  // sideband field positions
  localparam int SB_HEAD_LSB = 0;
  localparam int SB_TAIL_LSB = 4;
  // register map and reset values
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] PKT_CNT_OFS = 12'h008;
  localparam logic [11:0] NULL_CNT_OFS = 12'h00c;
  localparam logic [3:0] CTRL_RESET = 4'h3;
  localparam int CTRL_NS_EN = 0;
  localparam int CTRL_RO_EN = 1;
  localparam int CTRL_IDO_EN = 2;
  localparam int CTRL_ECRC_EN = 3;

  // true for every message request kind
  function automatic logic is_message(input logic [3:0] kind);
    return (kind == REQ_MSG) || (kind == REQ_MSG_VD) || (kind == REQ_MSG_ATS);
  endfunction
endpackage

// [verilog/desc_collector.sv]
// gathers the descriptor dwords from the leading beats of a packet
`timescale 1ns/1ps
module desc_collector import framer_pkg::*; #(
  parameter int DWORDS = 4
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic beat_fire,
  input wire logic beat_last,
  input wire logic [DWORDS*32-1:0] beat_data,
  output logic [DESC_W-1:0] desc_now,
  output logic [DWORDS-1:0] desc_lanes,
  output logic desc_done
);
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic [DESC_W-1:0] desc_r;
  logic [DESC_W-1:0] desc_nxt;

  // merge stored dwords with those arriving in this beat
  always_comb begin
    desc_nxt = desc_r;
    desc_lanes = '0;
    for (int j = 0; j < DESC_DWORDS; j++) begin
      if (j >= int'(cnt_r) && j - int'(cnt_r) < DWORDS) begin
        desc_nxt[j*32 +: 32] = beat_data[(j - int'(cnt_r))*32 +: 32];
        desc_lanes[j - int'(cnt_r)] = 1'b1;
      end
    end
  end

  assign desc_now = desc_nxt;
  assign desc_done = beat_fire && (cnt_r < 3'(DESC_DWORDS))
    && (int'(cnt_r) + DWORDS >= DESC_DWORDS);
  assign cnt_nxt = (int'(cnt_r) + DWORDS >= DESC_DWORDS) ? 3'(DESC_DWORDS)
    : cnt_r + 3'(DWORDS);

  // dword count restarts at the end of every packet
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= '0;
      desc_r <= '0;
    end else if (beat_fire) begin
      cnt_r <= beat_last ? 3'h0 : cnt_nxt;
      desc_r <= desc_nxt;
    end
  end
endmodule

// [verilog/tlp_header_builder.sv]
// forms the four request header dwords from a complete descriptor
`timescale 1ns/1ps
module tlp_header_builder import framer_pkg::*; (
  input wire logic [DESC_W-1:0] desc,
  input wire logic [3:0] head_mask,
  input wire logic [3:0] tail_mask,
  input wire logic [3:0] ctrl,
  input wire logic [7:0] cfg_bus_num,
  input wire logic [4:0] cfg_dev_num,
  output logic [127:0] hdr,
  output logic digest
);
  wire [3:0] kind = desc[REQ_TYPE_MSB:REQ_TYPE_LSB];
  wire msg = is_message(kind);
  wire [10:0] len = desc[LEN_MSB:LEN_LSB];
  wire [7:0] code = desc[MSG_CODE_MSB:MSG_CODE_LSB];
  // attributes masked by the function's enables
  wire ns = desc[NS_BIT] & ctrl[CTRL_NS_EN];
  wire ro = desc[RO_BIT] & ctrl[CTRL_RO_EN];
  wire ido = desc[IDO_BIT] & ctrl[CTRL_IDO_EN];
  wire [2:0] fmt = (len != 11'h0) ? FMT_4DW_DATA : FMT_4DW_NODATA;
  wire [4:0] typ = msg ? {TYPE_MSG_HI, desc[ROUTE_MSB:ROUTE_LSB]} : 5'h00;
  // requester id from descriptor or captured bus and device
  wire [15:0] rid = desc[RID_EN_BIT]
    ? {desc[REQ_BUS_MSB:REQ_BUS_LSB], desc[REQ_DEV_MSB:REQ_FN_LSB]}
    : {cfg_bus_num, cfg_dev_num, desc[REQ_FN_MSB:REQ_FN_LSB]};
  wire [31:0] dw0 = {fmt, typ, 1'b0, desc[TC_MSB:TC_LSB], 1'b0, ido, 2'h0,
    digest, 1'b0, ro, ns, 2'h0, len[9:0]};
  wire [31:0] dw1 = {rid, 8'h00, msg ? code : {tail_mask, head_mask}};
  logic [31:0] dw2;
  logic [31:0] dw3;

  assign digest = desc[FORCE_ECRC_BIT] | ctrl[CTRL_ECRC_EN];

  // message specific header dwords, address for memory writes
  always_comb begin
    dw2 = desc[63:32];
    dw3 = {desc[31:2], 2'h0};
    if (kind == REQ_MSG_VD) begin
      dw2 = {desc[15:0], 16'h0000};
      dw3 = desc[63:32];
    end else if (kind == REQ_MSG_ATS) begin
      dw2 = desc[31:0];
      dw3 = desc[63:32];
    end else if (msg && code == MSG_CODE_LTR) begin
      dw2 = 32'h0;
      dw3 = {desc[31:16], desc[15:0]};
    end else if (msg && code == MSG_CODE_OBFF) begin
      dw2 = 32'h0;
      dw3 = {28'h0, desc[OBFF_MSB:OBFF_LSB]};
    end else if (msg) begin
      dw2 = 32'h0;
      dw3 = 32'h0;
    end
  end

  assign hdr = {dw3, dw2, dw1, dw0};
endmodule

// [bench/rq_framer_sva.sv]
// port checks for the request framer
`timescale 1ns/1ps
module rq_framer_sva (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [127:0] req_stream_data,
  input wire logic req_stream_valid,
  input wire logic req_stream_ready,
  input wire logic req_stream_last,
  input wire logic [3:0] req_stream_dword_keep,
  input wire logic tlp_valid,
  input wire logic tlp_ready,
  input wire logic [127:0] tlp_data,
  input wire logic [3:0] tlp_keep,
  input wire logic tlp_last,
  input wire logic tlp_hdr_valid,
  input wire logic [127:0] tlp_hdr,
  input wire logic tlp_digest,
  input wire logic tlp_nullify
);
  logic open_r;
  wire logic fire = req_stream_valid & req_stream_ready;
  wire logic [127:0] d = req_stream_data;
  wire logic [3:0] t = req_stream_data[78:75];
  // packet open after a non-last beat
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) open_r <= 1'b0;
    else if (fire) open_r <= !req_stream_last;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence s_desc; fire && !open_r; endsequence
  sequence s_msg; fire && !open_r && t[3:2] == 2'b11 && t != 4'hf; endsequence
  chk_hdr_tc: assert property (
    s_desc |=> tlp_hdr_valid && tlp_hdr[22:20] == $past(d[123:121]))
    else $error("traffic class missing");
  chk_force_ecrc: assert property (s_desc ##0 d[127] |=> tlp_digest)
    else $error("digest missing");
  chk_msg_fields: assert property (
    s_msg |=> tlp_hdr[39:32] == $past(d[111:104]) && tlp_hdr[28:24] == {2'b10, $past(d[114:112])})
    else $error("message code or routing wrong");
  chk_ats_hdr: assert property (
    s_desc ##0 t == 4'he |=> tlp_hdr[127:64] == $past(d[63:0]))
    else $error("ats dwords wrong");
  chk_vd_hdr: assert property (
    s_desc ##0 t == 4'hd |=> tlp_hdr[127:96] == $past(d[63:32]))
    else $error("vendor dword wrong");
  chk_pay_pass: assert property (
    fire && open_r |=> !tlp_hdr_valid && tlp_data == $past(d) && tlp_last == $past(req_stream_last)
    && tlp_keep == $past(req_stream_dword_keep))
    else $error("payload beat altered");
  chk_out_hold: assert property (
    tlp_valid && !tlp_ready |=> tlp_valid && $stable(tlp_data) && $stable(tlp_hdr))
    else $error("output beat not held");
  chk_stall_ready: assert property (tlp_valid && !tlp_ready |-> !req_stream_ready)
    else $error("ready high during stall");
  chk_null_last: assert property (tlp_nullify |-> tlp_valid && tlp_last)
    else $error("nullify off last beat");
endmodule

// [bench/req_source.sv]
// user side request source: descriptor beat then payload beats
`timescale 1ns/1ps
module req_source (
  input wire logic mclk,
  input wire logic req_stream_ready,
  output logic [127:0] req_stream_data,
  output logic req_stream_valid,
  output logic req_stream_last,
  output logic [3:0] req_stream_dword_keep,
  output logic [7:0] req_stream_sideband
);
  // idle at time zero
  initial begin
    req_stream_data = '0;
    req_stream_valid = 1'b0;
    req_stream_last = 1'b0;
    req_stream_dword_keep = 4'h0;
    req_stream_sideband = 8'h0;
  end
  // hold the beat until the edge that takes it
  task automatic take();
    @(posedge mclk);
    while (req_stream_ready !== 1'b1) @(posedge mclk);
  endtask
  // one packet; drop opens a valid gap before later payload beats
  task automatic send(input logic [127:0] desc, input int ndw, input logic [7:0] sb,
    input bit drop);
    int left;
    left = ndw;
    @(posedge mclk);
    req_stream_valid <= 1'b1;
    req_stream_data <= desc;
    req_stream_dword_keep <= 4'hf;
    req_stream_sideband <= sb;
    req_stream_last <= (ndw == 0);
    take();
    while (left > 0) begin
      if (drop && left < ndw) begin
        req_stream_valid <= 1'b0;
        req_stream_data <= ~req_stream_data;
        @(posedge mclk);
      end
      req_stream_valid <= 1'b1;
      req_stream_data <= {4{desc[31:0] ^ 32'(left)}};
      req_stream_sideband <= ~sb;
      req_stream_dword_keep <= (left >= 4) ? 4'hf : 4'((1 << left) - 1);
      req_stream_last <= (left <= 4);
      left = left - 4;
      take();
    end
    req_stream_valid <= 1'b0;
    req_stream_last <= 1'b0;
    req_stream_data <= ~req_stream_data;
  endtask
endmodule

// [bench/tb_rq_descriptor_write_framer.sv]
// testbench: apb registers, random request packets, header checks
`timescale 1ns/1ps
`define CHK(nm, e, s) begin checked++; if ((e) !== (s)) begin n_fail++; \
  $display("wrong value %s exp %h seen %h", nm, e, s); end end
module tb_rq_descriptor_write_framer import framer_pkg::*; ;
  localparam logic [127:0] HMASK = {96'hffffffff_ffffffff_ffffffff, 32'hff74_b3ff};
  logic mclk, arst_n, psel, penable, pwrite, pready, pslverr, tlp_ready, got_dig;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed, rdy_s;
  logic [127:0] req_stream_data, tlp_data, tlp_hdr, got_hdr;
  logic req_stream_valid, req_stream_ready, req_stream_last, tlp_valid, tlp_last;
  logic tlp_hdr_valid, tlp_digest, tlp_nullify;
  logic [3:0] req_stream_dword_keep, tlp_keep;
  logic [7:0] req_stream_sideband, cfg_bus_num;
  logic [4:0] cfg_dev_num;
  logic [3:0] obff [3] = '{4'hf, 4'h1, 4'h0};
  int n_fail, checked, n_hdr, n_null;
  rq_descriptor_write_framer i_dut (.mclk, .arst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .req_stream_data, .req_stream_valid,
    .req_stream_ready, .req_stream_last, .req_stream_dword_keep, .req_stream_sideband,
    .cfg_bus_num, .cfg_dev_num, .tlp_valid, .tlp_ready, .tlp_data, .tlp_keep, .tlp_last,
    .tlp_hdr_valid, .tlp_hdr, .tlp_digest, .tlp_nullify);
  req_source i_src (.mclk, .req_stream_ready, .req_stream_data, .req_stream_valid,
    .req_stream_last, .req_stream_dword_keep, .req_stream_sideband);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // expected header from descriptor, control enables and byte masks
  function automatic logic [127:0] exp_hdr(input logic [127:0] d, input logic [3:0] c,
    input logic [7:0] sb);
    logic [127:0] h;
    logic [3:0] t;
    logic m;
    t = d[78:75];
    m = t == REQ_MSG || t == REQ_MSG_VD || t == REQ_MSG_ATS;
    h = '0;
    h[31:29] = (d[74:64] != 11'h0) ? FMT_4DW_DATA : FMT_4DW_NODATA;
    h[28:24] = m ? {TYPE_MSG_HI, d[114:112]} : 5'h0;
    h[22:20] = d[123:121];
    h[18] = d[126] & c[CTRL_IDO_EN];
    h[15] = d[127] | c[CTRL_ECRC_EN];
    h[13] = d[125] & c[CTRL_RO_EN];
    h[12] = d[124] & c[CTRL_NS_EN];
    h[9:0] = d[73:64];
    h[63:48] = d[120] ? d[95:80] : {cfg_bus_num, cfg_dev_num, d[82:80]};
    h[39:32] = m ? d[111:104] : sb;
    if (t == REQ_MEM_WR) h[127:64] = {d[31:2], 2'b0, d[63:32]};
    if (t == REQ_MSG_VD) h[127:64] = {d[63:32], d[15:0], 16'h0};
    if (t == REQ_MSG_ATS) h[127:64] = d[63:0];
    if (t == REQ_MSG && d[111:104] == MSG_CODE_LTR) h[127:96] = d[31:0];
    if (t == REQ_MSG && d[111:104] == MSG_CODE_OBFF) h[127:96] = {28'h0, d[35:32]};
    return h & HMASK;
  endfunction
  // one apb transfer, held until pready is sampled
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
    output logic [31:0] rd, output logic err);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // random stalls from the link side, output monitor
  // stall pattern restarts while reset is held, single driver of tlp_ready
  always @(posedge mclk) begin
    rdy_s <= (arst_n === 1'b1) ? lfsr(rdy_s) : 32'hc8dd;
    tlp_ready <= (arst_n === 1'b1) && (rdy_s[0] | rdy_s[3]);
    if (tlp_valid === 1'b1 && tlp_ready === 1'b1) begin
      if (tlp_hdr_valid === 1'b1) got_hdr <= tlp_hdr;
      if (tlp_hdr_valid === 1'b1) got_dig <= tlp_digest;
      if (tlp_hdr_valid === 1'b1) n_hdr <= n_hdr + 1;
      if (tlp_nullify === 1'b1) n_null <= n_null + 1;
    end
  end
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    final_report();
  end
  initial begin
    logic [31:0] rd;
    logic err;
    logic [127:0] d;
    logic [3:0] c;
    logic [7:0] sb;
    int k, h0;
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    cfg_bus_num = 8'h0;
    cfg_dev_num = 5'h0;
    seed = 32'hc8dd;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    apb(1'b0, CTRL_OFS, 32'h0, rd, err);
    `CHK("ctrl reset", {29'h0, CTRL_RESET}, {err, rd})
    apb(1'b1, STATUS_OFS, 32'hffff_ffff, rd, err);
    apb(1'b0, STATUS_OFS, 32'h0, rd, err);
    `CHK("status idle", 32'h0, rd)
    apb(1'b0, 12'h0f0, 32'h0, rd, err);
    `CHK("unmapped", 33'h1_0000_0000, {err, rd})
    $display("test registers done");
    for (int n = 0; n < 36; n++) begin
      k = n % 6;
      for (int i = 0; i < 4; i++) begin
        seed = lfsr(seed);
        d[i*32 +: 32] = seed;
      end
      c = seed[7:4];
      cfg_bus_num <= seed[15:8];
      cfg_dev_num <= seed[20:16];
      d[78:75] = (k == 0) ? REQ_MEM_WR : (k < 4) ? REQ_MSG : (k == 4) ? REQ_MSG_VD : REQ_MSG_ATS;
      if (k == 1) d[111:104] = MSG_CODE_LTR;
      if (k == 2) d[111:104] = MSG_CODE_OBFF;
      if (k == 2) d[35:32] = obff[n % 3];
      if (k == 4) d[114:112] = 3'b010;
      d[74:64] = (k == 0) ? 11'(1 + n / 6) : 11'(n % 2);
      d[11:6] = 6'h0;
      d[120] = seed[24];
      sb = (d[74:64] == 11'h1) ? {4'h0, seed[27:24]} : 8'h3c;
      apb(1'b1, CTRL_OFS, {28'h0, c}, rd, err);
      apb(1'b0, CTRL_OFS, 32'h0, rd, err);
      `CHK("ctrl", {28'h0, c}, rd)
      h0 = n_hdr;
      i_src.send(d, int'(d[74:64]), sb, n == 30);
      while (n_hdr == h0) @(posedge mclk);
      `CHK("header", exp_hdr(d, c, sb), got_hdr & HMASK)
      `CHK("digest", d[127] | c[3], got_dig)
      $display("test packet %0d done", n);
    end
    while (tlp_valid === 1'b1) @(posedge mclk);
    `CHK("null beats", 1, n_null)
    apb(1'b0, NULL_CNT_OFS, 32'h0, rd, err);
    `CHK("null count", 32'h1, rd)
    apb(1'b1, PKT_CNT_OFS, 32'h5, rd, err);
    apb(1'b0, PKT_CNT_OFS, 32'h0, rd, err);
    `CHK("count clear", 32'h0, rd)
    $display("test counts done");
    final_report();
  end
endmodule
bind rq_descriptor_write_framer rq_framer_sva i_sva (.mclk, .arst_n, .req_stream_data,
  .req_stream_valid, .req_stream_ready, .req_stream_last, .req_stream_dword_keep,
  .tlp_valid, .tlp_ready, .tlp_data, .tlp_keep, .tlp_last, .tlp_hdr_valid, .tlp_hdr,
  .tlp_digest, .tlp_nullify);
